// file: verilog/jibs_port.sv
// Purpose: shared test access port for core debug or boundary scan
// Assumes: tck comes from the probe; core side runs on mclk
// Notes: mode strap is caught once after chip reset release
`default_nettype none

module jibs_port #(
	parameter int NPADS = jibs_pkg::JIBS_PADS,
	// arbitrary value; bit 0 low marks it as not standard format
	parameter logic [31:0] ICE_IDCODE = 32'h0000_0a5e
) (
	// clocks and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic tck,
	// test pins
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic factory_test_select,
	input wire logic scan_mode_select,
	// core side
	input wire jibs_pkg::jibs_core_s core_in,
	output jibs_pkg::jibs_dbg_s dbg_out,
	output logic core_word_ready,
	input wire logic ice_protect,
	// pads
	input wire logic aux_in,
	input wire logic [NPADS-1:0] pad_in,
	input wire logic [NPADS-1:0] func_out,
	input wire logic [NPADS-1:0] func_oe,
	output logic [NPADS-1:0] pad_out,
	output logic [NPADS-1:0] pad_oe
);
	import jibs_pkg::*;

	typedef struct packed {
		logic strap_s1;
		logic strap_s2;
		logic [1:0] strap_cnt;
		logic bscan_mode;
		logic dreq_s1;
		logic dreq_s2;
		logic dseen;
		logic utgl;
		logic [31:0] uword;
		logic uack_s1;
		logic uack_s2;
		jibs_dbg_s dbg;
	} jibs_m_s;

	typedef struct packed {
		jibs_tap_e tap;
		jibs_ir_e ir;
		logic [3:0] ir_sh;
		logic [3:0] sel;
		logic [JIBS_DR_W-1:0] dr;
		logic mode_s1;
		logic mode_s2;
		logic prot_s1;
		logic prot_s2;
		logic ftst_s1;
		logic ftst_s2;
		logic halt_s1;
		logic halt_s2;
		logic dreq;
		jibs_kind_e dkind;
		logic [31:0] dword;
		logic dack_s1;
		logic dack_s2;
		logic up_s1;
		logic up_s2;
		logic uack;
	} jibs_t_s;

	jibs_m_s m;
	jibs_m_s next_m;
	jibs_t_s t;
	jibs_t_s next_t;
	jibs_dr_e pick;
	logic dbusy;
	logic rx_full;
	logic bsc_so;
	logic so_now;

	// --------------------------------
	// decoding
	// --------------------------------
	function automatic jibs_tap_e tap_next(jibs_tap_e s, logic ms);
		unique case (s)
			TLR: tap_next = ms ? TLR : RTI;
			RTI: tap_next = ms ? SELDR : RTI;
			SELDR: tap_next = ms ? SELIR : CAPDR;
			CAPDR: tap_next = ms ? EX1DR : SHDR;
			SHDR: tap_next = ms ? EX1DR : SHDR;
			EX1DR: tap_next = ms ? UPDR : PDR;
			PDR: tap_next = ms ? EX2DR : PDR;
			EX2DR: tap_next = ms ? UPDR : SHDR;
			UPDR: tap_next = ms ? SELDR : RTI;
			SELIR: tap_next = ms ? TLR : CAPIR;
			CAPIR: tap_next = ms ? EX1IR : SHIR;
			SHIR: tap_next = ms ? EX1IR : SHIR;
			EX1IR: tap_next = ms ? UPIR : PIR;
			PIR: tap_next = ms ? EX2IR : PIR;
			EX2IR: tap_next = ms ? UPIR : SHIR;
			UPIR: tap_next = ms ? SELDR : RTI;
		endcase
	endfunction : tap_next

	// unknown instructions fall back to the one-cell bypass
	function automatic jibs_dr_e dr_pick(jibs_ir_e ir, logic bscan, logic prot, logic [3:0] sel);
		dr_pick = D_BYP;
		if (bscan) begin
			if (ir == IR_EXTEST || ir == IR_SAMPLE) begin
				dr_pick = D_BSC;
			end
		end else if (ir == IR_IDCODE) begin
			dr_pick = D_IDC;
		end else if (ir == IR_SCAN_N) begin
			dr_pick = D_SCN;
		end else if (ir == IR_INTEST && !prot) begin
			if (sel == JIBS_SEL_CH0) dr_pick = D_CH0;
			else if (sel == JIBS_SEL_CH1) dr_pick = D_CH1;
			else if (sel == JIBS_SEL_CH2) dr_pick = D_CH2;
		end
	endfunction : dr_pick

	function automatic int dr_len(jibs_dr_e d);
		unique case (d)
			D_BYP, D_BSC: dr_len = 1;
			D_IDC: dr_len = 32;
			D_SCN: dr_len = 4;
			D_CH0: dr_len = 8;
			D_CH1: dr_len = 33;
			D_CH2: dr_len = 38;
		endcase
	endfunction : dr_len

	assign pick = dr_pick(t.ir, t.mode_s2, t.prot_s2, t.sel);
	assign dbusy = t.dreq != t.dack_s2;
	assign rx_full = t.up_s2 != t.uack;

	// --------------------------------
	// test clock domain
	// --------------------------------
	always_comb begin
		next_t = t;
		next_t.mode_s1 = m.bscan_mode;
		next_t.mode_s2 = t.mode_s1;
		next_t.prot_s1 = ice_protect;
		next_t.prot_s2 = t.prot_s1;
		next_t.ftst_s1 = factory_test_select;
		next_t.ftst_s2 = t.ftst_s1;
		next_t.halt_s1 = core_in.halted;
		next_t.halt_s2 = t.halt_s1;
		next_t.dack_s1 = m.dseen;
		next_t.dack_s2 = t.dack_s1;
		next_t.up_s1 = m.utgl;
		next_t.up_s2 = t.up_s1;
		next_t.tap = tap_next(t.tap, tms);
		unique case (t.tap)
			TLR: begin
				next_t.ir = t.mode_s2 ? IR_BYPASS : IR_IDCODE;
				next_t.sel = JIBS_SEL_CH0;
			end
			CAPIR: next_t.ir_sh = JIBS_IR_CAPT;
			SHIR: next_t.ir_sh = {tdi, t.ir_sh[3:1]};
			UPIR: begin
				next_t.ir = jibs_ir_e'(t.ir_sh);
				if (t.ir_sh == IR_RESTART && !t.mode_s2 && !t.prot_s2 && !dbusy) begin
					next_t.dreq = ~t.dreq;
					next_t.dkind = K_RST;
				end
			end
			CAPDR: begin
				unique case (pick)
					D_BYP, D_BSC: next_t.dr = '0;
					D_IDC: next_t.dr = JIBS_DR_W'(ICE_IDCODE);
					D_SCN: next_t.dr = JIBS_DR_W'(t.sel);
					D_CH0: next_t.dr = JIBS_DR_W'({t.halt_s2, rx_full, dbusy, t.prot_s2, 4'h0});
					D_CH1, D_CH2: begin
						// the word is stable while its toggle is unacknowledged
						next_t.dr = JIBS_DR_W'({rx_full, m.uword});
						next_t.uack = t.up_s2;
					end
				endcase
			end
			SHDR: begin
				next_t.dr = t.dr >> 1;
				next_t.dr[dr_len(pick)-1] = tdi;
			end
			UPDR: begin
				if (pick == D_SCN) begin
					next_t.sel = t.dr[3:0];
				end else if (pick == D_CH1 && t.dr[32] && t.halt_s2 && !dbusy) begin
					next_t.dreq = ~t.dreq;
					next_t.dkind = K_INSERT;
					next_t.dword = t.dr[31:0];
				end else if (pick == D_CH2 && t.dr[37] && !dbusy) begin
					if (t.dr[36:32] == JIBS_A_CTRL || t.dr[36:32] == JIBS_A_MONW) begin
						next_t.dreq = ~t.dreq;
						next_t.dkind = (t.dr[36:32] == JIBS_A_CTRL) ? K_CTRL : K_MONW;
						next_t.dword = t.dr[31:0];
					end
				end
			end
			RTI, SELDR, EX1DR, PDR, EX2DR, SELIR, EX1IR, PIR, EX2IR: ;
		endcase
	end

	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			t <= '{tap: TLR, ir: IR_IDCODE, dkind: K_CTRL, default: '0};
		end else begin
			t <= next_t;
		end
	end

	assign so_now = (t.tap == SHIR) ? t.ir_sh[0] : ((pick == D_BSC) ? bsc_so : t.dr[0]);

	// the probe samples on the rising edge, so data changes on the falling one
	always_ff @(negedge tck or negedge rstn) begin
		if (!rstn) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= so_now;
			tdo_oe <= (t.tap == SHIR || t.tap == SHDR) && !t.ftst_s2;
		end
	end

	jibs_bscan #(.NPADS(NPADS)) u_bscan (
		.tck(tck),
		.rstn(rstn),
		.tdi(tdi),
		.capture(t.tap == CAPDR && pick == D_BSC),
		.shift(t.tap == SHDR && pick == D_BSC),
		.update(t.tap == UPDR && pick == D_BSC),
		.extest(t.mode_s2 && t.ir == IR_EXTEST),
		.so(bsc_so),
		.aux_in(aux_in),
		.pad_in(pad_in),
		.func_out(func_out),
		.func_oe(func_oe),
		.pad_out(pad_out),
		.pad_oe(pad_oe)
	);

	// --------------------------------
	// core clock domain
	// --------------------------------
	always_comb begin
		next_m = m;
		next_m.strap_s1 = scan_mode_select;
		next_m.strap_s2 = m.strap_s1;
		if (m.strap_cnt == JIBS_STRAP_WAIT) begin
			next_m.bscan_mode = m.strap_s2;
		end
		if (m.strap_cnt != JIBS_STRAP_DONE) begin
			next_m.strap_cnt = m.strap_cnt + 2'h1;
		end
		next_m.dbg.restart = 1'b0;
		next_m.dbg.insn_valid = 1'b0;
		next_m.dbg.mon_valid = 1'b0;
		next_m.dreq_s1 = t.dreq;
		next_m.dreq_s2 = m.dreq_s1;
		if (m.dreq_s2 != m.dseen) begin
			next_m.dseen = m.dreq_s2;
			unique case (t.dkind)
				K_CTRL: next_m.dbg.halt_req = t.dword[0];
				K_INSERT: begin
					next_m.dbg.insn_valid = 1'b1;
					next_m.dbg.word = t.dword;
				end
				K_MONW: begin
					next_m.dbg.mon_valid = 1'b1;
					next_m.dbg.word = t.dword;
				end
				K_RST: begin
					next_m.dbg.restart = 1'b1;
					next_m.dbg.halt_req = 1'b0;
				end
			endcase
		end
		next_m.uack_s1 = t.uack;
		next_m.uack_s2 = m.uack_s1;
		if (core_in.word_valid && core_word_ready) begin
			next_m.utgl = ~m.utgl;
			next_m.uword = core_in.word;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			m <= '0;
		end else begin
			m <= next_m;
		end
	end

	assign core_word_ready = m.utgl == m.uack_s2;
	assign dbg_out = m.dbg;

	// --------------------------------
	// checks
	// --------------------------------
	sequence tms_five_s;
		tms [*5];
	endsequence

	tap_reset_a: assert property (@(posedge tck) disable iff (!rstn)
		tms_five_s |=> (t.tap == TLR))
		else $error("five tms highs did not reach reset state");
	bypass_one_a: assert property (@(posedge tck) disable iff (!rstn)
		(t.tap == SHDR && pick == D_BYP) |=> (t.dr[0] == $past(tdi)))
		else $error("bypass path is not one cell");
	ice_route_a: assert property (@(posedge tck) disable iff (!rstn)
		!t.mode_s2 |-> (pick != D_BSC))
		else $error("debug use reached boundary chain");
	bsc_route_a: assert property (@(posedge tck) disable iff (!rstn)
		(t.mode_s2 && (t.ir == IR_SAMPLE || t.ir == IR_EXTEST)) |-> (pick == D_BSC))
		else $error("boundary instruction not routed to chain");
	protect_a: assert property (@(posedge tck) disable iff (!rstn)
		(t.prot_s2 && t.ir == IR_INTEST) |-> (pick == D_BYP))
		else $error("protected port reached a core chain");
	idcode_a: assert property (@(posedge tck) disable iff (!rstn)
		(t.tap == CAPDR && pick == D_IDC) |=> (t.dr[31:0] == ICE_IDCODE))
		else $error("wrong identification value captured");
	insert_a: assert property (@(posedge tck) disable iff (!rstn)
		(t.tap == UPDR && pick == D_CH1 && t.dr[32] && t.halt_s2 && !dbusy)
		|=> (t.dkind == K_INSERT && t.dword == $past(t.dr[31:0]) && dbusy))
		else $error("store insertion not posted");
	export_ack_a: assert property (@(posedge tck) disable iff (!rstn)
		(t.tap == CAPDR && pick == D_CH1 && rx_full) |=> !rx_full)
		else $error("exported word not acknowledged");
	mode_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		(m.strap_cnt == JIBS_STRAP_DONE) |=> $stable(m.bscan_mode))
		else $error("mode changed without reset");
	word_take_a: assert property (@(posedge mclk) disable iff (!rstn)
		(core_in.word_valid && core_word_ready) |=> (!core_word_ready && m.uword == $past(core_in.word)))
		else $error("core word not held for the port");
endmodule : jibs_port

`default_nettype wire

// file: inc/jibs_pkg.sv
// Purpose: shared types and constants of the test and debug port
// Assumes: one tap serves either core debug or boundary scan, fixed at reset
// Notes: instruction and tap state codes are the usual four-bit ones
`default_nettype none

package jibs_pkg;
	// --------------------------------
	// sizes and counts
	// --------------------------------
	localparam int JIBS_PADS = 62;
	localparam int JIBS_DR_W = 38;
	localparam logic [3:0] JIBS_IR_CAPT = 4'h1;
	localparam logic [3:0] JIBS_SEL_CH0 = 4'h0;
	localparam logic [3:0] JIBS_SEL_CH1 = 4'h1;
	localparam logic [3:0] JIBS_SEL_CH2 = 4'h2;
	localparam logic [4:0] JIBS_A_CTRL = 5'h00;
	localparam logic [4:0] JIBS_A_MONW = 5'h01;
	localparam logic [1:0] JIBS_STRAP_WAIT = 2'h2;
	localparam logic [1:0] JIBS_STRAP_DONE = 2'h3;

	// --------------------------------
	// enumerations
	// --------------------------------
	typedef enum logic [3:0] {
		TLR = 4'hf, RTI = 4'hc, SELDR = 4'h7, CAPDR = 4'h6, SHDR = 4'h2, EX1DR = 4'h1,
		PDR = 4'h3, EX2DR = 4'h0, UPDR = 4'h5, SELIR = 4'h4, CAPIR = 4'he, SHIR = 4'ha,
		EX1IR = 4'h9, PIR = 4'hb, EX2IR = 4'h8, UPIR = 4'hd
	} jibs_tap_e;

	typedef enum logic [3:0] {
		IR_EXTEST = 4'h0, IR_SCAN_N = 4'h2, IR_SAMPLE = 4'h3, IR_RESTART = 4'h4,
		IR_INTEST = 4'hc, IR_IDCODE = 4'he, IR_BYPASS = 4'hf
	} jibs_ir_e;

	typedef enum logic [2:0] {
		D_BYP = 3'h0, D_BSC = 3'h1, D_IDC = 3'h2, D_SCN = 3'h3,
		D_CH0 = 3'h4, D_CH1 = 3'h5, D_CH2 = 3'h6
	} jibs_dr_e;

	typedef enum logic [1:0] {
		K_CTRL = 2'h0, K_INSERT = 2'h1, K_MONW = 2'h2, K_RST = 2'h3
	} jibs_kind_e;

	// --------------------------------
	// carriers to and from the core
	// --------------------------------
	typedef struct packed {
		logic halted;
		logic word_valid;
		logic [31:0] word;
	} jibs_core_s;

	typedef struct packed {
		logic halt_req;
		logic restart;
		logic insn_valid;
		logic mon_valid;
		logic [31:0] word;
	} jibs_dbg_s;
endpackage : jibs_pkg

`default_nettype wire

// file: verilog/jibs_bscan.sv
// Purpose: boundary cell chain, one input-only cell plus three cells per pad
// Assumes: runs on the test clock; pad and function levels are asynchronous
// Notes: cell 0 input-only; pad i uses 3i+1 direction, 3i+2 drive, 3i+3 observe
`default_nettype none

module jibs_bscan #(
	parameter int NPADS = jibs_pkg::JIBS_PADS
) (
	// link clock and reset
	input wire logic tck,
	input wire logic rstn,
	// from the tap
	input wire logic tdi,
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic extest,
	output logic so,
	// pads and core function
	input wire logic aux_in,
	input wire logic [NPADS-1:0] pad_in,
	input wire logic [NPADS-1:0] func_out,
	input wire logic [NPADS-1:0] func_oe,
	output logic [NPADS-1:0] pad_out,
	output logic [NPADS-1:0] pad_oe
);
	import jibs_pkg::*;

	localparam int LEN = 3 * NPADS + 1;

	typedef struct packed {
		logic [LEN-1:0] s1;
		logic [LEN-1:0] s2;
		logic [LEN-1:0] sh;
		logic [LEN-1:0] upd;
	} jibs_bsc_s;

	jibs_bsc_s r;
	jibs_bsc_s next_r;
	logic [LEN-1:0] obs;

	// --------------------------------
	// cell map
	// --------------------------------
	assign obs[0] = aux_in;
	for (genvar i = 0; i < NPADS; i++) begin : g_pad
		assign obs[3*i+1] = func_oe[i];
		assign obs[3*i+2] = func_out[i];
		assign obs[3*i+3] = pad_in[i];
		assign pad_out[i] = extest ? r.upd[3*i+2] : func_out[i];
		assign pad_oe[i] = extest ? r.upd[3*i+1] : func_oe[i];
	end

	// --------------------------------
	// chain
	// --------------------------------
	// every observed level is synchronised, so a capture never sees a metastable cell
	always_comb begin
		next_r = r;
		next_r.s1 = obs;
		next_r.s2 = r.s1;
		if (capture) begin
			next_r.sh = r.s2;
		end else if (shift) begin
			next_r.sh = {tdi, r.sh[LEN-1:1]};
		end
		if (update) begin
			next_r.upd = r.sh;
		end
	end

	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign so = r.sh[0];

	ext_drive_a: assert property (@(posedge tck) disable iff (!rstn)
		extest |-> (pad_out[0] == r.upd[2] && pad_oe[NPADS-1] == r.upd[LEN-3]))
		else $error("extest does not drive pads from the chain");
	obs_capture_a: assert property (@(posedge tck) disable iff (!rstn)
		capture |=> (r.sh == $past(r.s2)))
		else $error("capture did not load observed levels");
endmodule : jibs_bscan

`default_nettype wire

// file: verif/jibs_probe.sv
// Purpose: probe model that drives the serial test port
// Assumes: tck rests low between scans, 15 ns period inside a scan
// Notes: tms and tdi change at falling tck; tdo is read just before rising tck
`default_nettype none

module jibs_probe (
	// test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------
	// tap sequencing
	// --------------------------------
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#7.5;
		q = tdo;
		tck = 1'b1;
		#7.5;
		tck = 1'b0;
	endtask : tick

	// five highs reach reset from any state, then park in run-test idle
	task automatic idle();
		logic q;
		for (int i = 0; i < 5; i++) begin
			tick(1'b1, 1'b0, q);
		end
		tick(1'b0, 1'b0, q);
	endtask : idle

	task automatic scan(input logic ir, input int n, input logic [199:0] din,
		output logic [199:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b0, q);
		if (ir) begin
			tick(1'b1, 1'b0, q);
		end
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], dout[i]);
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask : scan
endmodule : jibs_probe

`default_nettype wire

// file: verif/jibs_port_tb.sv
// Purpose: self-checking bench of the shared test port
// Assumes: probe model drives tck; bench drives core and pads at falling mclk
// Notes: seed 68; expectations come from the bench functions
`default_nettype none

module jibs_port_tb;
	import jibs_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------
	// setup
	// --------------------------------
	localparam int NC = 3 * JIBS_PADS + 1;
	logic mclk, rstn, tck, tms, tdi, tdo, tdo_oe, strap, prot, aux, ready;
	jibs_core_s core;
	jibs_dbg_s dbg;
	logic [JIBS_PADS-1:0] pin, fo, foe, pout, poe;
	// arbitrary value; bit 0 low marks it as not standard format
	localparam logic [31:0] ICE_ID = 32'h0000_0a5e;
	int failures, samples_checked, n_ins, n_mon, n_rst, n_oe;
	logic [31:0] w_ins, w_mon, r;
	logic [199:0] d, q;

	jibs_port #(.ICE_IDCODE(ICE_ID)) jibs_port_inst (.mclk(mclk), .rstn(rstn), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .factory_test_select(1'b0),
		.scan_mode_select(strap), .core_in(core), .dbg_out(dbg), .core_word_ready(ready),
		.ice_protect(prot), .aux_in(aux), .pad_in(pin), .func_out(fo), .func_oe(foe),
		.pad_out(pout), .pad_oe(poe));
	jibs_probe jibs_probe_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// pulses stand one mclk cycle, so look at them mid-cycle
	always @(negedge mclk) begin
		if (dbg.insn_valid === 1'b1) begin
			n_ins++;
			w_ins = dbg.word;
		end
		if (dbg.mon_valid === 1'b1) begin
			n_mon++;
			w_mon = dbg.word;
		end
		if (dbg.restart === 1'b1) begin
			n_rst++;
		end
	end

	// the enable must stand at exactly the rising edges that sample a shifted bit
	always @(posedge tck) begin
		if (tdo_oe === 1'b1) begin
			n_oe++;
		end
	end

	function automatic logic [199:0] exp_byp(input logic [199:0] v, input int n);
		return (v << 1) & ((200'h1 << n) - 200'h1);
	endfunction : exp_byp

	task automatic check(input string what, input logic [199:0] exp, input logic [199:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	task automatic do_reset(input logic s);
		@(negedge mclk);
		rstn = 1'b0;
		strap = s;
		repeat (16) @(negedge mclk);
		rstn = 1'b1;
		repeat (10) @(negedge mclk);
		jibs_probe_inst.idle();
	endtask : do_reset

	task automatic ir(input logic [3:0] c);
		jibs_probe_inst.scan(1'b1, 4, 200'(c), q);
	endtask : ir

	task automatic dr(input int n, input logic [199:0] v);
		jibs_probe_inst.scan(1'b0, n, v, q);
	endtask : dr

	task automatic chain(input logic [3:0] c);
		ir(IR_SCAN_N);
		dr(4, 200'(c));
		ir(IR_INTEST);
	endtask : chain

	task automatic await(ref int c, input int want);
		for (int i = 0; i < 40 && c != want; i++) begin
			@(negedge mclk);
		end
	endtask : await

	initial begin
		// the tests need about a dozen microseconds; this leaves a wide margin
		#400us;
		failures++;
		stop_test();
	end

	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		{rstn, strap, prot, aux} = '0;
		{core, pin, fo, foe} = '0;
		{failures, samples_checked, n_ins, n_mon, n_rst, n_oe} = '0;
		r = $urandom(68);
		do_reset(1'b0);
		ir(IR_IDCODE);
		check("ir capture", 200'(JIBS_IR_CAPT), q);
		dr(32, '0);
		check("debug ident", 200'(ICE_ID), q);
		check("output enable", 200'(36), 200'(n_oe));
		ir(IR_BYPASS);
		d = 200'($urandom);
		dr(32, d);
		check("bypass ice", exp_byp(d, 32), q);
		$display("test ident and bypass ended");

		@(negedge mclk);
		core.halted = 1'b1;
		chain(JIBS_SEL_CH0);
		dr(8, '0);
		check("status", 200'(8'h80), q);
		r = $urandom;
		@(negedge mclk);
		core.word = r;
		core.word_valid = 1'b1;
		for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
			@(negedge mclk);
		end
		@(negedge mclk);
		core.word_valid = 1'b0;
		check("ready drop", 200'(0), 200'(ready));
		chain(JIBS_SEL_CH1);
		dr(33, '0);
		check("export word", 200'({1'b1, r}), q);
		repeat (4) @(negedge mclk);
		check("ready back", 200'(1), 200'(ready));
		r = $urandom;
		dr(33, 200'({1'b1, r}));
		await(n_ins, 1);
		check("insert word", 200'({2'h1, r}), 200'({n_ins[1:0], w_ins}));
		$display("test halt export ended");

		chain(JIBS_SEL_CH2);
		r = $urandom;
		dr(38, 200'({1'b1, JIBS_A_MONW, r}));
		await(n_mon, 1);
		check("monitor word", 200'({2'h1, r}), 200'({n_mon[1:0], w_mon}));
		dr(38, 200'({1'b1, JIBS_A_CTRL, 32'h1}));
		repeat (10) @(negedge mclk);
		check("halt request", 200'(1), 200'(dbg.halt_req));
		ir(IR_RESTART);
		await(n_rst, 1);
		repeat (4) @(negedge mclk);
		check("restart", 200'(3'h2), 200'({n_rst[1:0], dbg.halt_req}));
		@(negedge mclk);
		prot = 1'b1;
		ir(IR_INTEST);
		d = 200'($urandom);
		dr(32, d);
		check("protected", exp_byp(d, 32), q);
		$display("test monitor and protect ended");

		do_reset(1'b1);
		ir(IR_IDCODE);
		dr(32, d);
		check("bscan ident", exp_byp(d, 32), q);
		@(negedge mclk);
		pin = JIBS_PADS'({$urandom, $urandom});
		fo = JIBS_PADS'({$urandom, $urandom});
		foe = JIBS_PADS'({$urandom, $urandom});
		aux = 1'b1;
		d = 200'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
		ir(IR_SAMPLE);
		dr(NC + 1, d);
		check("chain length", 200'(d[0]), 200'(q[NC]));
		check("aux cell", 200'(1), 200'(q[0]));
		for (int i = 0; i < JIBS_PADS; i++) begin
			check("observe cell", 200'(pin[i]), 200'(q[3 * i + 3]));
			check("drive capture", 200'(fo[i]), 200'(q[3 * i + 2]));
			check("direction capture", 200'(foe[i]), 200'(q[3 * i + 1]));
		end
		check("pads follow core", 200'({fo, foe}), 200'({pout, poe}));
		ir(IR_EXTEST);
		for (int i = 0; i < JIBS_PADS; i++) begin
			check("drive cell", 200'(d[3 * i + 3]), 200'(pout[i]));
			check("direction cell", 200'(d[3 * i + 2]), 200'(poe[i]));
		end
		$display("test boundary ended");
		stop_test();
	end
endmodule : jibs_port_tb

`default_nettype wire
